// File: hw/iohr_pkg.sv
// Constants, carriers and helpers for the I/O override and status holding registers
package iohr_pkg;

  // ----------------------------------------------------------------
  // Function codes and exception answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  IOHR_FC_READ     = 8'h03;
  localparam logic [7:0]  IOHR_FC_WRITE1   = 8'h06;
  localparam logic [7:0]  IOHR_FC_WRITEN   = 8'h10;
  localparam logic [7:0]  IOHR_EXC_NONE    = 8'h00;
  localparam logic [7:0]  IOHR_EXC_FUNC    = 8'h01;
  localparam logic [7:0]  IOHR_EXC_ADDR    = 8'h02;

  // ----------------------------------------------------------------
  // Address space and register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] IOHR_SPAN_LO     = 16'h9C40;
  localparam logic [15:0] IOHR_SPAN_HI     = 16'hABDF;
  localparam logic [15:0] IOHR_GROUP_LAST  = 16'hA027;
  localparam logic [15:0] IOHR_USED_LAST   = 16'h9C52;
  localparam logic [15:0] IOHR_AI_FAULT    = 16'h9C40;
  localparam logic [15:0] IOHR_CTR_FAULT   = 16'h9C41;
  localparam logic [15:0] IOHR_FRQ_FAULT   = 16'h9C42;
  localparam logic [15:0] IOHR_AI_LOCAL    = 16'h9C43;
  localparam logic [15:0] IOHR_DI_LOCAL    = 16'h9C44;
  localparam logic [15:0] IOHR_CTR_LOCAL   = 16'h9C45;
  localparam logic [15:0] IOHR_FRQ_LOCAL   = 16'h9C46;
  localparam logic [15:0] IOHR_AI_EN       = 16'h9C47;
  localparam logic [15:0] IOHR_DI_EN       = 16'h9C48;
  localparam logic [15:0] IOHR_CTR_EN      = 16'h9C49;
  localparam logic [15:0] IOHR_FRQ_EN      = 16'h9C4A;
  localparam logic [15:0] IOHR_AO_LOCAL    = 16'h9C4B;
  localparam logic [15:0] IOHR_DO_LOCAL    = 16'h9C4C;
  localparam logic [15:0] IOHR_AO_ALARM    = 16'h9C4D;
  localparam logic [15:0] IOHR_DO_ALARM    = 16'h9C4E;
  localparam logic [15:0] IOHR_AO_COPY     = 16'h9C4F;
  localparam logic [15:0] IOHR_DO_COPY     = 16'h9C50;
  localparam logic [15:0] IOHR_AO_EN       = 16'h9C51;
  localparam logic [15:0] IOHR_DO_EN       = 16'h9C52;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          IOHR_N_IN        = 6;
  localparam int          IOHR_N_OUT       = 4;
  localparam logic [15:0] IOHR_EN_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iohr_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
    logic [7:0]  exc;
  } iohr_rsp_t;

  // Bit 0 is channel one; outputs order solid-state one, two, relay one, two
  typedef struct packed {
    logic [5:0] ai_fault;
    logic [5:0] ctr_fault;
    logic [5:0] frq_fault;
    logic [5:0] ai_local;
    logic [5:0] di_local;
    logic [5:0] ctr_local;
    logic [5:0] frq_local;
    logic [3:0] ao_local;
    logic [3:0] do_local;
    logic [3:0] ao_alarm;
    logic [3:0] do_alarm;
    logic [3:0] ao_copy;
    logic [3:0] do_copy;
  } iohr_status_t;

  typedef struct packed {
    logic [5:0] ai;
    logic [5:0] di;
    logic [5:0] ctr;
    logic [5:0] frq;
    logic [3:0] ao;
    logic [3:0] dout;
  } iohr_force_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic iohr_in_span(input logic [15:0] a);
    return (a >= IOHR_SPAN_LO) && (a <= IOHR_SPAN_HI);
  endfunction : iohr_in_span

  function automatic logic [15:0] iohr_pad6(input logic [5:0] v);
    return {10'h000, v};
  endfunction : iohr_pad6

  function automatic logic [15:0] iohr_pad4(input logic [3:0] v);
    return {12'h000, v};
  endfunction : iohr_pad4

endpackage : iohr_pkg

// File: hw/iohr_sync.sv
// Two-flop synchroniser for the channel status levels
`timescale 1ns/1ps
`default_nettype none
module iohr_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : iohr_sync
`default_nettype wire

// File: hw/iohr_force_mask.sv
// One remote override enable mask with its blocking conditions
`timescale 1ns/1ps
`default_nettype none
module iohr_force_mask #(
  parameter int W = 6
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         wr_stb,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] block,
  output var  logic [W-1:0] en_q
);

  logic [W-1:0] en_d;

  // A blocked channel is dropped on write and on every cycle its block is high
  always_comb begin
    en_d = (wr_stb ? wr_data : en_q) & ~block;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_q <= '0;
    end else begin
      en_q <= en_d;
    end
  end

endmodule : iohr_force_mask
`default_nettype wire

// File: hw/iohr_regs.sv
// Holding register bank: range faults, override status and remote override masks
`timescale 1ns/1ps
`default_nettype none
module iohr_regs
  import iohr_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire iohr_req_t    req_i,
  input  wire iohr_status_t status_i,
  output var  iohr_rsp_t    rsp_o,
  output var  iohr_force_t  force_o
);

  // ----------------------------------------------------------------
  // Status capture
  // ----------------------------------------------------------------
  iohr_status_t st;

  // Status levels come from the field side, so they are resynchronised
  iohr_sync #(
    .W ($bits(iohr_status_t))
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .async_i (status_i),
    .sync_o  (st)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic        fc_read;
  logic        fc_write;
  logic        in_span;
  logic [7:0]  exc_d;
  logic        wr_ok;
  logic [15:0] rd_word;

  assign fc_read  = (req_i.func == IOHR_FC_READ);
  assign fc_write = (req_i.func == IOHR_FC_WRITE1) ||
                    (req_i.func == IOHR_FC_WRITEN);
  assign in_span  = iohr_in_span(req_i.addr);

  always_comb begin
    if (!(fc_read || fc_write)) begin
      exc_d = IOHR_EXC_FUNC;
    end else if (!in_span) begin
      exc_d = IOHR_EXC_ADDR;
    end else begin
      exc_d = IOHR_EXC_NONE;
    end
  end

  // Writes reach only the mask words; any other address drops the data
  assign wr_ok = req_i.valid && fc_write && in_span;

  // ----------------------------------------------------------------
  // Remote override masks
  // ----------------------------------------------------------------
  logic [5:0] ai_en;
  logic [5:0] di_en;
  logic [5:0] ctr_en;
  logic [5:0] frq_en;
  logic [3:0] ao_en;
  logic [3:0] do_en;
  logic [3:0] ao_blk;
  logic [3:0] do_blk;

  // Outputs are also blocked by alarm and recopy, inputs by local override
  assign ao_blk = st.ao_local | st.ao_alarm | st.ao_copy;
  assign do_blk = st.do_local | st.do_alarm | st.do_copy;

  iohr_force_mask #(.W(IOHR_N_IN)) u_ai_en (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_stb  (wr_ok && (req_i.addr == IOHR_AI_EN)),
    .wr_data (req_i.wdata[5:0]),
    .block   (st.ai_local),
    .en_q    (ai_en)
  );

  iohr_force_mask #(.W(IOHR_N_IN)) u_di_en (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_stb  (wr_ok && (req_i.addr == IOHR_DI_EN)),
    .wr_data (req_i.wdata[5:0]),
    .block   (st.di_local),
    .en_q    (di_en)
  );

  iohr_force_mask #(.W(IOHR_N_IN)) u_ctr_en (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_stb  (wr_ok && (req_i.addr == IOHR_CTR_EN)),
    .wr_data (req_i.wdata[5:0]),
    .block   (st.ctr_local),
    .en_q    (ctr_en)
  );

  iohr_force_mask #(.W(IOHR_N_IN)) u_frq_en (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_stb  (wr_ok && (req_i.addr == IOHR_FRQ_EN)),
    .wr_data (req_i.wdata[5:0]),
    .block   (st.frq_local),
    .en_q    (frq_en)
  );

  iohr_force_mask #(.W(IOHR_N_OUT)) u_ao_en (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_stb  (wr_ok && (req_i.addr == IOHR_AO_EN)),
    .wr_data (req_i.wdata[3:0]),
    .block   (ao_blk),
    .en_q    (ao_en)
  );

  iohr_force_mask #(.W(IOHR_N_OUT)) u_do_en (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_stb  (wr_ok && (req_i.addr == IOHR_DO_EN)),
    .wr_data (req_i.wdata[3:0]),
    .block   (do_blk),
    .en_q    (do_en)
  );

  // Mask flops drive the force lines directly
  assign force_o = {ai_en,
                    di_en,
                    ctr_en,
                    frq_en,
                    ao_en,
                    do_en};

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    case (req_i.addr)
      IOHR_AI_FAULT:  rd_word = iohr_pad6(st.ai_fault);
      IOHR_CTR_FAULT: rd_word = iohr_pad6(st.ctr_fault);
      IOHR_FRQ_FAULT: rd_word = iohr_pad6(st.frq_fault);
      IOHR_AI_LOCAL:  rd_word = iohr_pad6(st.ai_local);
      IOHR_DI_LOCAL:  rd_word = iohr_pad6(st.di_local);
      IOHR_CTR_LOCAL: rd_word = iohr_pad6(st.ctr_local);
      IOHR_FRQ_LOCAL: rd_word = iohr_pad6(st.frq_local);
      IOHR_AI_EN:     rd_word = iohr_pad6(ai_en);
      IOHR_DI_EN:     rd_word = iohr_pad6(di_en);
      IOHR_CTR_EN:    rd_word = iohr_pad6(ctr_en);
      IOHR_FRQ_EN:    rd_word = iohr_pad6(frq_en);
      IOHR_AO_LOCAL:  rd_word = iohr_pad4(st.ao_local);
      IOHR_DO_LOCAL:  rd_word = iohr_pad4(st.do_local);
      IOHR_AO_ALARM:  rd_word = iohr_pad4(st.ao_alarm);
      IOHR_DO_ALARM:  rd_word = iohr_pad4(st.do_alarm);
      IOHR_AO_COPY:   rd_word = iohr_pad4(st.ao_copy);
      IOHR_DO_COPY:   rd_word = iohr_pad4(st.do_copy);
      IOHR_AO_EN:     rd_word = iohr_pad4(ao_en);
      IOHR_DO_EN:     rd_word = iohr_pad4(do_en);
      default:        rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.valid;
      rsp_o.func  <= req_i.func;
      rsp_o.addr  <= req_i.addr;
      rsp_o.exc   <= exc_d;
      // A write is echoed as taken, even to a read-only word
      if (fc_read && in_span) begin
        rsp_o.data <= rd_word;
      end else if (fc_write && in_span) begin
        rsp_o.data <= req_i.wdata;
      end else begin
        rsp_o.data <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic rd_in;
  logic wr_nb_ai;
  logic wr_nb_do;
  assign rd_in    = req_i.valid && fc_read && in_span;
  assign wr_nb_ai = wr_ok && (req_i.addr == IOHR_AI_EN);
  assign wr_nb_do = wr_ok && (req_i.addr == IOHR_DO_EN);

  answer_timing_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_i.valid |=> rsp_o.valid && (rsp_o.addr == $past(req_i.addr)))
    else $error("request not answered next cycle");

  bad_func_a: assert property (@(posedge sys_clk) disable iff (rst)
    (req_i.valid && !fc_read && !fc_write) |=> (rsp_o.exc == IOHR_EXC_FUNC))
    else $error("unknown function code not refused");

  span_check_a: assert property (@(posedge sys_clk) disable iff (rst)
    (req_i.valid && (fc_read || fc_write)) |=>
      ((rsp_o.exc == IOHR_EXC_ADDR) == !iohr_in_span($past(req_i.addr))))
    else $error("span decode wrong");

  unused_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr > IOHR_USED_LAST)) |=> (rsp_o.data == 16'h0000))
    else $error("unused word reads non-zero");

  ai_fault_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_AI_FAULT)) |=>
      (rsp_o.data == {10'h000, $past(st.ai_fault)}))
    else $error("analog fault word wrong");

  ctr_fault_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_CTR_FAULT)) |=>
      (rsp_o.data == {10'h000, $past(st.ctr_fault)}))
    else $error("counter fault word wrong");

  do_local_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_DO_LOCAL)) |=>
      (rsp_o.data == {12'h000, $past(st.do_local)}))
    else $error("digital output local word wrong");

  ai_mask_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_nb_ai |=> (ai_en == ($past(req_i.wdata[5:0]) & ~$past(st.ai_local))))
    else $error("analog input mask not written");

  do_mask_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr_nb_do |=> (do_en == ($past(req_i.wdata[3:0]) & ~$past(do_blk))))
    else $error("digital output mask not written");

  out_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ao_blk != 4'h0) |=> ((ao_en & $past(ao_blk)) == 4'h0))
    else $error("blocked analog output still forced");

  in_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    (($past(di_en) & st.di_local) != 6'h00) |=> ((di_en & $past(st.di_local)) == 6'h00))
    else $error("digital input force not cleared");

  ro_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ok && (req_i.addr != IOHR_AI_EN) && (st.ai_local == 6'h00)) ##1
      (st.ai_local == 6'h00) |-> (ai_en == $past(ai_en)))
    else $error("mask changed by foreign write");

  frq_fault_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_FRQ_FAULT)) |=>
      (rsp_o.data == {10'h000, $past(st.frq_fault)}))
    else $error("frequency fault word wrong");

  ai_local_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_AI_LOCAL)) |=>
      (rsp_o.data == {10'h000, $past(st.ai_local)}))
    else $error("analog input local word wrong");

  di_local_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_DI_LOCAL)) |=>
      (rsp_o.data == {10'h000, $past(st.di_local)}))
    else $error("digital input local word wrong");

  ctr_local_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_CTR_LOCAL)) |=>
      (rsp_o.data == {10'h000, $past(st.ctr_local)}))
    else $error("counter input local word wrong");

  frq_local_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_FRQ_LOCAL)) |=>
      (rsp_o.data == {10'h000, $past(st.frq_local)}))
    else $error("frequency input local word wrong");

  ao_local_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_AO_LOCAL)) |=>
      (rsp_o.data == {12'h000, $past(st.ao_local)}))
    else $error("analog output local word wrong");

  ao_alarm_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_AO_ALARM)) |=>
      (rsp_o.data == {12'h000, $past(st.ao_alarm)}))
    else $error("analog output alarm word wrong");

  do_alarm_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_DO_ALARM)) |=>
      (rsp_o.data == {12'h000, $past(st.do_alarm)}))
    else $error("digital output alarm word wrong");

  ao_copy_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_AO_COPY)) |=>
      (rsp_o.data == {12'h000, $past(st.ao_copy)}))
    else $error("analog output recopy word wrong");

  do_copy_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_DO_COPY)) |=>
      (rsp_o.data == {12'h000, $past(st.do_copy)}))
    else $error("digital output recopy word wrong");

  ctr_mask_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_in && (req_i.addr == IOHR_CTR_EN)) |=>
      (rsp_o.data == {10'h000, $past(ctr_en)}))
    else $error("counter input mask reads wrong");

  refused_data_a: assert property (@(posedge sys_clk) disable iff (rst)
    (req_i.valid && (exc_d != IOHR_EXC_NONE)) |=> (rsp_o.data == 16'h0000))
    else $error("refused request returns data");

  write_echo_a: assert property (@(posedge sys_clk) disable iff (rst)
    (req_i.valid && fc_write && in_span) |=>
      (rsp_o.data == $past(req_i.wdata)))
    else $error("write data not echoed");

  di_mask_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ok && (req_i.addr == IOHR_DI_EN)) |=>
      (di_en == ($past(req_i.wdata[5:0]) & ~$past(st.di_local))))
    else $error("digital input mask not written");

  ao_mask_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ok && (req_i.addr == IOHR_AO_EN)) |=>
      (ao_en == ($past(req_i.wdata[3:0]) & ~$past(ao_blk))))
    else $error("analog output mask not written");

  in_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st.ai_local != 6'h00) |=> ((ai_en & $past(st.ai_local)) == 6'h00))
    else $error("blocked analog input still forced");

  out_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    (($past(do_en) & do_blk) != 4'h0) |=> ((do_en & $past(do_blk)) == 4'h0))
    else $error("digital output force not cleared");

endmodule : iohr_regs
`default_nettype wire

// File: test/iohr_client.sv
// Modbus client model issuing word requests to the holding register bank
`timescale 1ns/1ps
`default_nettype none
module iohr_client
  import iohr_pkg::*;
(
  input  wire logic      sys_clk,
  output var  iohr_req_t req_o,
  input  wire iohr_rsp_t rsp_i
);
  initial req_o = '0;

  // ----------------------------------------------------------------
  // Word transfer
  // ----------------------------------------------------------------
  // Entered just after a falling edge; a chained call keeps the strobe up
  // so multiple-write words go out back to back
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      input bit last, output iohr_rsp_t r);
    req_o.valid = 1'b1;
    req_o.func  = f;
    req_o.addr  = a;
    req_o.wdata = d;
    @(negedge sys_clk);
    r = rsp_i;
    if (last) begin
      // Released fields flip so a stale sample shows up
      req_o.valid = 1'b0;
      req_o.addr  = ~a;
      req_o.wdata = ~d;
      @(negedge sys_clk);
    end
  endtask : xfer
endmodule : iohr_client
`default_nettype wire

// File: test/test_io_override_status_holding_regs.sv
// Self-checking bench for the override and status holding registers
`timescale 1ns/1ps
`default_nettype none
module test_io_override_status_holding_regs
  import iohr_pkg::*;
;
  logic         sys_clk;
  logic         rst;
  iohr_req_t    req;
  iohr_rsp_t    rsp;
  iohr_status_t st;
  iohr_force_t  frc;
  int           error_cnt;
  int           cmp_count;
  int           en[6];

  iohr_regs i_dut (.sys_clk(sys_clk), .rst(rst), .req_i(req), .status_i(st),
                   .rsp_o(rsp), .force_o(frc));
  iohr_client i_cli (.sys_clk(sys_clk), .req_o(req), .rsp_i(rsp));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic int blk(input int k);
    case (k)
      0: return st.ai_local;
      1: return st.di_local;
      2: return st.ctr_local;
      3: return st.frq_local;
      4: return st.ao_local | st.ao_alarm | st.ao_copy;
      default: return st.do_local | st.do_alarm | st.do_copy;
    endcase
  endfunction : blk

  function automatic int rd_word(input int i);
    int w[19];
    w = '{st.ai_fault, st.ctr_fault, st.frq_fault, st.ai_local, st.di_local, st.ctr_local,
          st.frq_local, en[0], en[1], en[2], en[3], st.ao_local, st.do_local, st.ao_alarm,
          st.do_alarm, st.ao_copy, st.do_copy, en[4], en[5]};
    return (i < 19) ? w[i] : 0;
  endfunction : rd_word

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic chk_force();
    iohr_force_t e;
    e = {6'(en[0]), 6'(en[1]), 6'(en[2]), 6'(en[3]), 4'(en[4]), 4'(en[5])};
    cmp_count++;
    if (frc !== e) begin
      error_cnt++;
      $display("CHECK FAILED force_o expected %0h seen %0h", e, frc);
    end
  endtask : chk_force

  task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                     input bit last);
    iohr_rsp_t r;
    int i;
    int k;
    int ex;
    int ed;
    i  = int'(a) - int'(IOHR_SPAN_LO);
    k  = (i >= 7 && i <= 10) ? i - 7 : (i == 17 || i == 18) ? i - 13 : -1;
    ex = (f != 8'h03 && f != 8'h06 && f != 8'h10) ? 1 : (i < 0 || i > 3999) ? 2 : 0;
    ed = (ex != 0) ? 0 : (f == 8'h03) ? rd_word(i) : int'(d);
    if (ex == 0 && f != 8'h03 && k >= 0) begin
      en[k] = int'(d) & ((k < 4) ? 'h3F : 'hF) & ~blk(k);
    end
    i_cli.xfer(f, a, d, last, r);
    chk("rsp_valid", 32'h1, 32'(r.valid));
    chk("rsp_func", 32'(f), 32'(r.func));
    if (last) chk("rsp_idle", 32'h0, 32'(rsp.valid));
    chk("rsp_exc", ex, 32'(r.exc));
    chk("rsp_addr", 32'(a), 32'(r.addr));
    chk("rsp_data", ed, 32'(r.data));
    chk_force();
  endtask : acc

  task automatic set_status(input iohr_status_t s);
    st = s;
    // Two sync flops plus the mask flop
    repeat (4) @(negedge sys_clk);
    for (int k = 0; k < 6; k++) en[k] &= ~blk(k);
    chk_force();
  endtask : set_status

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] bnd[5];
    logic [15:0] wv[10];
    logic [7:0]  fl[3];
    logic [7:0]  f;
    logic [15:0] a;
    int          r;
    bnd = '{16'hABDF, 16'hABE0, 16'hA027, 16'hFFFF, 16'h0000};
    wv  = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0003,
            16'h0014, 16'h0030, 16'h0000};
    fl  = '{8'h03, 8'h06, 8'h10};
    error_cnt = 0;
    cmp_count = 0;
    rst = 1'b1;
    st = '0;
    foreach (en[k]) en[k] = 0;
    void'($urandom(52412));
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk_force();
    for (int n = 0; n < 22; n++) acc(8'h03, 16'h9C3F + 16'(n), 16'hFFFF, 1'b1);
    foreach (bnd[n]) acc(8'h03, bnd[n], 16'h0000, 1'b1);
    foreach (bnd[n]) acc(8'h06, bnd[n], 16'h1234, 1'b1);
    foreach (fl[n]) acc(8'h00 + 8'(n) * 8'h05, 16'h9C47, 16'h0001, 1'b1);
    acc(8'h2B, 16'h0000, 16'h0001, 1'b1);
    // Weighted mask values on every writable word, chained multiple writes
    foreach (wv[n]) begin
      acc(8'h06, 16'h9C47, wv[n], 1'b1);
      acc(8'h10, 16'h9C48, wv[n], 1'b0);
      acc(8'h10, 16'h9C49, wv[n], 1'b0);
      acc(8'h10, 16'h9C4A, wv[n] | 16'hFFC0, 1'b1);
      acc(8'h06, 16'h9C51, wv[n], 1'b1);
      acc(8'h06, 16'h9C52, wv[n], 1'b1);
      acc(8'h03, 16'h9C47, 16'h0000, 1'b1);
    end
    acc(8'h06, 16'h9C51, 16'hFFFF, 1'b1);
    set_status(66'h1 << 12);
    acc(8'h06, 16'h9C51, 16'h000F, 1'b1);
    // Random status batches with mixed traffic
    for (int b = 0; b < 8; b++) begin
      set_status(66'({$urandom, $urandom, $urandom} & {$urandom, $urandom, $urandom}));
      for (int n = 0; n < 30; n++) begin
        r = $urandom % 8;
        a = (r < 6) ? 16'h9C40 + 16'($urandom % 21) :
            (r == 6) ? 16'h9C40 + 16'($urandom % 4000) : 16'($urandom);
        f = fl[$urandom % 3];
        if (r < 7 && $urandom % 6 == 0) f = 8'($urandom);
        acc(f, a, 16'($urandom), (f != 8'h10) || (n == 29) || ($urandom % 2 == 1));
      end
    end
    end_of_test();
  end
endmodule : test_io_override_status_holding_regs
`default_nettype wire
